// file: verilog/line_unit_setup_control.v
// Command handler applying setup and adjust requests to the line units.
//
// Notes on behaviour
// - Check hardware support before initialising unit.
// - Success answers with status zero.
// - Every unit starts disabled after reset.
// - Kind 1 off, 3/5 E1, 4 T1.
// - Kind mismatching fitted hardware is rejected.
// - Coding 1 HDB3, 2 AMI, 4 B8ZS.
// - Framing 1 and 2 are E1 only.
// - Framing 3, 4, 7, 8 are T1 only.
// - Framing 9 is J1, needs T1 kind.
// - Checksum 1 off, 2 CRC4, 4 CRC6.
// - Shape 0 E1, 1-6 short haul, 7/11 bad.
// - Shapes 8, 9, 10, 12 are long haul.
// - Setup alarm 1 off, 2 on.
// - Monitor 1 normal, 2 high impedance.
// - Clock bit 0 disables recovery, others zero.
// - Adjust alarm 0 keep, 1 off, 2 on.
// - Loop 0 keep, 1 none, 2-4 loops.
// - Pattern 0 keep, 1 stop, 3 QRSS.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_consts.vh"
module line_unit_setup_control (
  input wire clock,
  input wire reset,
  input wire clockEnable,
  input wire reqValid,
  input wire [15:0] reqType,
  input wire [`UNIT_IDX_W-1:0] lineUnitIndex,
  input wire [127:0] reqParams,
  input wire [`UNIT_COUNT-1:0] fittedT1,
  output wire reqReady,
  output reg respValid_r,
  output reg [7:0] respStatus_r,
  output reg [`UNIT_COUNT-1:0] unitEnabled_r,
  output reg [`UNIT_COUNT*8-1:0] unitKind_r,
  output reg [`UNIT_COUNT*8-1:0] unitCoding_r,
  output reg [`UNIT_COUNT*8-1:0] unitFraming_r,
  output reg [`UNIT_COUNT*8-1:0] unitChecksum_r,
  output reg [`UNIT_COUNT*8-1:0] unitShape_r,
  output reg [`UNIT_COUNT-1:0] unitBlueAlarm_r,
  output reg [`UNIT_COUNT-1:0] unitHighZ_r,
  output reg [`UNIT_COUNT-1:0] unitNoRecover_r,
  output reg [`UNIT_COUNT*8-1:0] unitLoop_r,
  output reg [`UNIT_COUNT-1:0] unitPattern_r,
  output reg [`UNIT_COUNT-1:0] unitInit_r
);
  // ****************************************
  // Request field extraction
  // ****************************************
  wire [7:0] pKind = reqParams[7:0];
  wire [7:0] pCoding = reqParams[15:8];
  wire [7:0] pFraming = reqParams[23:16];
  wire [7:0] pChecksum = reqParams[31:24];
  wire [7:0] pShape = reqParams[39:32];
  wire [7:0] pAlarm = reqParams[95:88];
  wire [7:0] pMonitor = reqParams[103:96];
  wire [15:0] pClock = reqParams[119:104];
  wire [7:0] aAlarm = reqParams[7:0];
  wire [7:0] aLoop = reqParams[23:16];
  wire [7:0] aPattern = reqParams[39:32];
  wire [7:0] checkStatus;
  wire unitOk = ({1'b0, lineUnitIndex} < `UNIT_COUNT);
  wire selFitted = fittedT1[lineUnitIndex];
  reg [7:0] adjStatus;

  // The handler never stalls; a request is taken every enabled cycle.
  assign reqReady = 1'b1;

  // ****************************************
  // Hardware and parameter check
  // ****************************************
  setup_checker paramCheck (
    .kind(pKind),
    .coding(pCoding),
    .framing(pFraming),
    .checksum(pChecksum),
    .shape(pShape),
    .alarmSel(pAlarm),
    .monitorSel(pMonitor),
    .clockBits(pClock),
    .fittedT1(selFitted),
    .status(checkStatus)
  );

  always @* begin
    adjStatus = `ST_OK;
    if (aAlarm > `SEL_ON) begin
      adjStatus = `ST_BAD_PARAM;
    end
    if (aLoop > `LOOP_LOCAL) begin
      adjStatus = `ST_BAD_PARAM;
    end
    if (aPattern != `SEL_KEEP && aPattern != `SEL_OFF && aPattern != `PAT_QRSS) begin
      adjStatus = `ST_BAD_PARAM;
    end
  end

  // ****************************************
  // Unit state and answers
  // ****************************************
  // Each request is checked fully before any unit state is touched, so a
  // refused request leaves the unit exactly as it was.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      respValid_r <= 1'b0;
      respStatus_r <= 8'h00;
      unitEnabled_r <= {`UNIT_COUNT{1'b0}};
      unitKind_r <= {`UNIT_COUNT{`RST_KIND}};
      unitCoding_r <= {`UNIT_COUNT*8{1'b0}};
      unitFraming_r <= {`UNIT_COUNT*8{1'b0}};
      unitChecksum_r <= {`UNIT_COUNT*8{1'b0}};
      unitShape_r <= {`UNIT_COUNT*8{1'b0}};
      unitBlueAlarm_r <= {`UNIT_COUNT{1'b0}};
      unitHighZ_r <= {`UNIT_COUNT{1'b0}};
      unitNoRecover_r <= {`UNIT_COUNT{1'b0}};
      unitLoop_r <= {`UNIT_COUNT*8{1'b0}};
      unitPattern_r <= {`UNIT_COUNT{1'b0}};
      unitInit_r <= {`UNIT_COUNT{1'b0}};
    end else if (clockEnable) begin
      respValid_r <= 1'b0;
      unitInit_r <= {`UNIT_COUNT{1'b0}};
      if (reqValid) begin
        respValid_r <= 1'b1;
        if (!unitOk) begin
          respStatus_r <= `ST_BAD_UNIT;
        end else if (reqType == `MSG_SETUP) begin
          respStatus_r <= checkStatus;
          if (checkStatus == `ST_OK) begin
            // Whole configuration replaced at once.
            unitInit_r[lineUnitIndex] <= 1'b1;
            unitEnabled_r[lineUnitIndex] <= (pKind != `KIND_OFF);
            unitKind_r[lineUnitIndex*8 +: 8] <= pKind;
            unitCoding_r[lineUnitIndex*8 +: 8] <= pCoding;
            unitFraming_r[lineUnitIndex*8 +: 8] <= pFraming;
            unitChecksum_r[lineUnitIndex*8 +: 8] <= pChecksum;
            unitShape_r[lineUnitIndex*8 +: 8] <= pShape;
            unitBlueAlarm_r[lineUnitIndex] <= (pAlarm == `SEL_ON);
            unitHighZ_r[lineUnitIndex] <= (pMonitor == `SEL_ON);
            unitNoRecover_r[lineUnitIndex] <= pClock[`CLK_NORECOVER_BIT];
            unitLoop_r[lineUnitIndex*8 +: 8] <= `SEL_OFF;
            unitPattern_r[lineUnitIndex] <= 1'b0;
          end
        end else if (reqType == `MSG_ADJUST) begin
          respStatus_r <= adjStatus;
          if (adjStatus == `ST_OK) begin
            if (aAlarm != `SEL_KEEP) begin
              unitBlueAlarm_r[lineUnitIndex] <= (aAlarm == `SEL_ON);
            end
            if (aLoop != `SEL_KEEP) begin
              unitLoop_r[lineUnitIndex*8 +: 8] <= aLoop;
            end
            if (aPattern != `SEL_KEEP) begin
              unitPattern_r[lineUnitIndex] <= (aPattern == `PAT_QRSS);
            end
          end
        end else begin
          respStatus_r <= `ST_BAD_MSG;
        end
      end
    end
  end
endmodule // line_unit_setup_control
`default_nettype wire

// file: verilog/line_unit_consts.vh
// Constants for the line unit setup and control command handler.
`ifndef LINE_UNIT_CONSTS_VH
`define LINE_UNIT_CONSTS_VH
`define UNIT_COUNT 4
`define UNIT_IDX_W 2
`define MSG_SETUP 16'h7e34
`define MSG_ADJUST 16'h7e35
`define KIND_OFF 8'h01
`define KIND_E1A 8'h03
`define KIND_T1 8'h04
`define KIND_E1 8'h05
`define CODE_HDB3 8'h01
`define CODE_AMI 8'h02
`define CODE_B8ZS 8'h04
`define FRM_DBL 8'h01
`define FRM_CRC4 8'h02
`define FRM_F4 8'h03
`define FRM_D4 8'h04
`define FRM_ESF 8'h07
`define FRM_F72 8'h08
`define FRM_J1 8'h09
`define CHK_OFF 8'h01
`define CHK_CRC4 8'h02
`define CHK_CRC6 8'h04
`define SHAPE_E1 8'h00
`define SHAPE_SH_MAX 8'h06
`define SHAPE_LH0 8'h08
`define SHAPE_LH10 8'h0a
`define SHAPE_LH12 8'h0c
`define SHAPE_BAD1 8'h07
`define SHAPE_BAD2 8'h0b
`define SEL_KEEP 8'h00
`define SEL_OFF 8'h01
`define SEL_ON 8'h02
`define LOOP_LOCAL 8'h04
`define PAT_QRSS 8'h03
`define CLK_NORECOVER_BIT 0
`define ST_OK 8'h00
`define ST_BAD_MSG 8'h01
`define ST_BAD_HW 8'h02
`define ST_BAD_PARAM 8'h03
`define ST_BAD_UNIT 8'h04
`define CFG_W 56
`define RST_KIND 8'h01
`endif

// file: verilog/setup_checker.v
// Validation of one line setup request against the fitted hardware.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_consts.vh"
module setup_checker (
  input wire [7:0] kind,
  input wire [7:0] coding,
  input wire [7:0] framing,
  input wire [7:0] checksum,
  input wire [7:0] shape,
  input wire [7:0] alarmSel,
  input wire [7:0] monitorSel,
  input wire [15:0] clockBits,
  input wire fittedT1,
  output reg [7:0] status
);
  reg isE1;
  reg isT1;
  reg ok;
  always @* begin
    isE1 = (kind == `KIND_E1) || (kind == `KIND_E1A);
    isT1 = (kind == `KIND_T1);
    ok = 1'b1;
    status = `ST_OK;
    if (!(isE1 || isT1 || kind == `KIND_OFF)) begin
      status = `ST_BAD_PARAM;
    end else if ((isE1 && fittedT1) || (isT1 && !fittedT1)) begin
      status = `ST_BAD_HW;
    end else if (kind != `KIND_OFF) begin
      case (coding)
        `CODE_HDB3: ok = isE1;
        `CODE_AMI: ok = 1'b1;
        `CODE_B8ZS: ok = isT1;
        default: ok = 1'b0;
      endcase
      case (framing)
        `FRM_DBL, `FRM_CRC4: ok = ok && isE1;
        `FRM_F4, `FRM_D4, `FRM_ESF, `FRM_F72: ok = ok && isT1;
        `FRM_J1: ok = ok && isT1;
        default: ok = 1'b0;
      endcase
      case (checksum)
        `CHK_OFF: ok = ok;
        `CHK_CRC4: ok = ok && (framing == `FRM_CRC4);
        `CHK_CRC6: ok = ok && (framing == `FRM_ESF);
        default: ok = 1'b0;
      endcase
      if (shape == `SHAPE_E1) begin
        ok = ok && isE1;
      end else if (shape <= `SHAPE_SH_MAX || (shape >= `SHAPE_LH0 && shape <= `SHAPE_LH12 &&
          shape != `SHAPE_BAD2)) begin
        ok = ok && isT1;
      end else begin
        ok = 1'b0;
      end
      ok = ok && (alarmSel == `SEL_OFF || alarmSel == `SEL_ON);
      ok = ok && (monitorSel == `SEL_OFF || monitorSel == `SEL_ON);
      ok = ok && (clockBits[15:1] == 15'h0000);
      if (!ok) begin
        status = `ST_BAD_PARAM;
      end
    end
  end
endmodule // setup_checker
`default_nettype wire

// file: verif/line_unit_setup_control_assertions.sv
// Port checks for the line unit setup and control handler.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_consts.vh"
module line_unit_setup_control_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic reqValid,
  input wire logic [15:0] reqType,
  input wire logic [`UNIT_IDX_W-1:0] lineUnitIndex,
  input wire logic [127:0] reqParams,
  input wire logic [`UNIT_COUNT-1:0] fittedT1,
  input wire logic reqReady,
  input wire logic respValid_r,
  input wire logic [7:0] respStatus_r,
  input wire logic [`UNIT_COUNT-1:0] unitEnabled_r,
  input wire logic [`UNIT_COUNT*8-1:0] unitKind_r,
  input wire logic [`UNIT_COUNT-1:0] unitInit_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence sTake;
    clockEnable && reqValid;
  endsequence
  sequence sFail;
    respValid_r && respStatus_r != `ST_OK;
  endsequence
  a_answer_next: assert property (sTake |=> respValid_r) else $error("no answer");
  a_no_spurious: assert property (clockEnable && !reqValid |=> !respValid_r)
    else $error("answer without request");
  a_always_ready: assert property (reqReady) else $error("ready low");
  a_bad_type: assert property ((sTake and (reqType != `MSG_SETUP && reqType != `MSG_ADJUST))
    |=> respStatus_r == `ST_BAD_MSG) else $error("bad type accepted");
  a_kind_fit: assert property ((sTake and (reqType == `MSG_SETUP
    && reqParams[7:0] inside {`KIND_E1A, `KIND_T1, `KIND_E1}
    && ((reqParams[7:0] == `KIND_T1) != fittedT1[lineUnitIndex])))
    |=> respStatus_r == `ST_BAD_HW) else $error("kind mismatch accepted");
  a_fail_keeps: assert property (sFail |-> $stable(unitKind_r))
    else $error("rejected setup changed unit");
  a_init_ok: assert property (|unitInit_r |-> respValid_r && respStatus_r == `ST_OK)
    else $error("init without success");
  a_init_one: assert property ($onehot0(unitInit_r)) else $error("several inits");
  a_enable_kind: assert property (unitEnabled_r == {unitKind_r[31:24] != `KIND_OFF,
    unitKind_r[23:16] != `KIND_OFF, unitKind_r[15:8] != `KIND_OFF,
    unitKind_r[7:0] != `KIND_OFF}) else $error("enable disagrees with kind");
  a_freeze_hold: assert property (!clockEnable |=> $stable(respValid_r)
    && $stable(respStatus_r) && $stable(unitKind_r)) else $error("state moved while frozen");
endmodule // line_unit_setup_control_assertions
bind line_unit_setup_control line_unit_setup_control_assertions chk (.clock, .reset,
  .clockEnable, .reqValid, .reqType, .lineUnitIndex, .reqParams, .fittedT1, .reqReady,
  .respValid_r, .respStatus_r, .unitEnabled_r, .unitKind_r, .unitInit_r);
`default_nettype wire

// file: verif/host_request_model.sv
// Host side model issuing setup and adjust requests.
`timescale 1ns/1ps
`default_nettype none
module host_request_model (
  input wire logic clock,
  output logic reqValid,
  output logic [15:0] reqType,
  output logic [1:0] lineUnitIndex,
  output logic [127:0] reqParams
);
  initial reqValid = 1'b0;
  initial reqType = 16'h0000;
  initial lineUnitIndex = 2'h0;
  initial reqParams = '0;
  // Released lines show inverted data so stale values never look valid.
  task automatic send(input logic [15:0] t, input logic [1:0] i, input logic [127:0] p);
    @(posedge clock);
    #1;
    reqValid = 1'b1;
    reqType = t;
    lineUnitIndex = i;
    reqParams = p;
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    reqType = ~t;
    lineUnitIndex = ~i;
    reqParams = ~p;
  endtask
endmodule // host_request_model
`default_nettype wire

// file: verif/line_unit_setup_control_tb.sv
// Self-checking bench for the line unit setup and control handler.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_consts.vh"
module line_unit_setup_control_tb;
  logic clock, reset, clockEnable, reqValid, reqReady, respValid_r;
  logic [15:0] reqType;
  logic [1:0] lineUnitIndex;
  logic [127:0] reqParams;
  logic [7:0] respStatus_r;
  logic [3:0] fittedT1, unitEnabled_r, unitBlueAlarm_r, unitHighZ_r, unitNoRecover_r;
  logic [3:0] unitPattern_r, unitInit_r;
  logic [31:0] unitKind_r, unitCoding_r, unitFraming_r, unitChecksum_r, unitShape_r, unitLoop_r;
  int errCount = 0;
  int checks = 0;
  line_unit_setup_control uut (.clock, .reset, .clockEnable, .reqValid, .reqType,
    .lineUnitIndex, .reqParams, .fittedT1, .reqReady, .respValid_r, .respStatus_r,
    .unitEnabled_r, .unitKind_r, .unitCoding_r, .unitFraming_r, .unitChecksum_r,
    .unitShape_r, .unitBlueAlarm_r, .unitHighZ_r, .unitNoRecover_r, .unitLoop_r,
    .unitPattern_r, .unitInit_r);
  host_request_model host (.clock, .reqValid, .reqType, .lineUnitIndex, .reqParams);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task req(input logic [15:0] t, input logic [1:0] i, input logic [127:0] p, input logic [7:0] s);
    host.send(t, i, p);
    chk(respValid_r, 1);
    chk(respStatus_r, s);
  endtask
  function logic [127:0] su(input logic [7:0] k, c, f, m, b, a, z, input logic [15:0] x);
    return {8'h00, x, z, a, 48'h0, b, m, f, c, k};
  endfunction
  function logic [127:0] adj(input logic [7:0] a, l, p);
    return {88'h0, p, 8'h00, l, 8'h00, a};
  endfunction
  task finalReport;
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    errCount++;
    finalReport;
  end
  initial begin
    reset = 1'b1;
    clockEnable = 1'b1;
    fittedT1 = 4'b0101;
    repeat (10) @(posedge clock);
    #1 reset = 1'b0;
    chk(unitEnabled_r, 0);
    chk(unitKind_r, 32'h0101_0101);
    chk({reqReady, respValid_r, unitInit_r}, 6'h20);
    req(`MSG_SETUP, 1, su(5, 1, 2, 2, 0, 2, 1, 0), 0);
    chk(unitInit_r, 4'b0010);
    chk({unitEnabled_r, unitBlueAlarm_r}, 8'h22);
    chk({unitKind_r[15:8], unitCoding_r[15:8], unitChecksum_r[15:8]}, 24'h05_0102);
    req(`MSG_SETUP, 0, su(4, 4, 7, 4, 9, 1, 2, 16'h0001), 0);
    chk({unitHighZ_r, unitNoRecover_r}, 8'h11);
    chk(unitFraming_r[7:0], `FRM_ESF);
    for (int s = 0; s < 13; s++)
      req(`MSG_SETUP, 0, su(4, 2, 4, 1, s, 1, 1, 0), (s inside {0, 7, 11}) ? 3 : 0);
    req(`MSG_SETUP, 0, su(4, 2, 3, 1, 1, 1, 1, 0), 0);
    req(`MSG_SETUP, 0, su(4, 2, 8, 1, 1, 1, 1, 0), 0);
    req(`MSG_SETUP, 0, su(4, 2, 9, 1, 12, 1, 1, 0), 0);
    req(`MSG_SETUP, 2, su(3, 2, 1, 1, 0, 1, 1, 0), `ST_BAD_HW);
    req(`MSG_SETUP, 3, su(4, 2, 4, 1, 1, 1, 1, 0), `ST_BAD_HW);
    req(`MSG_SETUP, 1, su(3, 1, 9, 1, 0, 1, 1, 0), `ST_BAD_PARAM);
    req(`MSG_SETUP, 1, su(3, 2, 1, 2, 0, 1, 1, 0), `ST_BAD_PARAM);
    req(`MSG_SETUP, 0, su(4, 2, 4, 1, 1, 1, 1, 16'h0002), `ST_BAD_PARAM);
    chk(unitShape_r[7:0], `SHAPE_LH12);
    req(16'h7e36, 1, 0, `ST_BAD_MSG);
    req(`MSG_ADJUST, 1, adj(0, 0, 0), 0);
    chk(unitBlueAlarm_r[1], 1);
    req(`MSG_ADJUST, 1, adj(1, 0, 0), 0);
    chk(unitBlueAlarm_r[1], 0);
    for (int l = 1; l < 5; l++) begin
      req(`MSG_ADJUST, 1, adj(0, l, 0), 0);
      chk(unitLoop_r[15:8], l);
    end
    req(`MSG_ADJUST, 1, adj(0, 0, 3), 0);
    req(`MSG_ADJUST, 1, adj(0, 0, 0), 0);
    chk({unitPattern_r[1], unitLoop_r[15:8]}, 9'h104);
    req(`MSG_ADJUST, 1, adj(0, 5, 1), `ST_BAD_PARAM);
    req(`MSG_ADJUST, 1, adj(0, 0, 1), 0);
    chk({unitPattern_r[1], unitLoop_r[15:8]}, 9'h004);
    // A request offered while the enable is low must not be taken at all.
    clockEnable = 1'b0;
    host.send(`MSG_ADJUST, 1, adj(0, 5, 0));
    chk({respStatus_r, unitLoop_r[15:8]}, 16'h0004);
    clockEnable = 1'b1;
    req(`MSG_SETUP, 1, su(1, 0, 0, 0, 0, 0, 0, 0), 0);
    chk(unitEnabled_r, 4'b0001);
    finalReport;
  end
endmodule // line_unit_setup_control_tb
`default_nettype wire
